/* File: pio_board.sv */
// Board model: header wires with pulls and outside drivers.
// Assumes the port's pad outputs and bench-set outside drive.
`timescale 1ns/10ps
`default_nettype none
module pio_board
   import pio_pkg::*;
#(
   parameter int LINES = PIO_LINES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [LINES-1:0] pin_out,
   input wire logic [LINES-1:0] pin_oe,
   input wire logic [LINES-1:0] pin_pull_en,
   input wire logic [LINES-1:0] pin_pull_up,
   input wire logic [LINES-1:0] ext_en,
   input wire logic [LINES-1:0] ext_val,
   output logic [LINES-1:0] pin_in
);
   logic [LINES-1:0] float_q = '0; // Floating wire, changes each cycle
   logic [LINES-1:0] ext_ok; // Outside drive actually applied
   logic [LINES-1:0] keep_hi; // Lines 26 and 29

   // Toggle so a floating wire never looks settled
   always_ff @(posedge aclk)
   begin
      float_q <= ~float_q;
   end

   // Never pull 26 or 29 low while reset runs
   always_comb
   begin
      keep_hi = LINES'(32'h2400_0000);
      ext_ok = aresetn ? ext_en : ext_en & ~(keep_hi & ~ext_val);
   end

   // Device drive wins, then outside, then pull, else float
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_ok & ext_val) |
      (~pin_oe & ~ext_ok & pin_pull_en & pin_pull_up) |
      (~pin_oe & ~ext_ok & ~pin_pull_en & float_q);
endmodule
`default_nettype wire

/* File: pio_line.sv */
// One I/O line: decodes its mode and registers its pad drive and read value.
// Assumes pad_in is synchronous to clk and the board resolves the wire.
`timescale 1ns/10ps
`default_nettype none
module pio_line
   import pio_pkg::*;
#(
   parameter bit PULL_UP = 1'b1,   // Fixed pull sense of this line
   parameter bit INVERTED = 1'b0,  // Board inverter in the path
   parameter bit FUNC_RST = 1'b0,  // Function bit after reset
   parameter bit DIR_RST = 1'b1    // Direction bit after reset
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic func,
   input wire logic dir,
   input wire logic open_drain,
   input wire logic dat,
   input wire logic periph_out,
   input wire logic periph_oe,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic pad_pull_en,
   output logic pad_pull_up,
   output logic rd_val
);

   // All line state in one record
   typedef struct packed {
      logic out;
      logic oe;
      logic pull_en;
      logic rd;
   } pio_line_st_t;

   pio_line_st_t st_q; // Registered state
   pio_line_st_t st_d; // Next state
   pio_mode_t mode;    // Decoded mode

   // Mode decode and pad drive
   always_comb
   begin
      mode = pio_mode_t'({func, dir});
      st_d = st_q;
      st_d.rd = pad_in ^ INVERTED;
      st_d.out = 1'b0;
      st_d.oe = 1'b0;
      st_d.pull_en = 1'b0;
      case (mode)
         PIO_MODE_NORMAL:
         begin
            // Shared peripheral owns the pad
            st_d.out = periph_out;
            st_d.oe = periph_oe;
         end
         PIO_MODE_IN_PULL:
            st_d.pull_en = 1'b1;
         PIO_MODE_OUT:
         begin
            // Inverter-fed lines never drive in output mode
            if (!INVERTED)
            begin
               if (open_drain)
               begin
                  st_d.out = 1'b0;
                  st_d.oe = ~dat;
               end
               else
               begin
                  st_d.out = dat;
                  st_d.oe = 1'b1;
               end
            end
         end
         PIO_MODE_IN_FREE:
            st_d.pull_en = 1'b0;
         default:
            st_d.pull_en = 1'b0;
      endcase
   end

   // Register; reset pull enable mirrors the reset mode of this line, pad drive resets off
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q.out <= 1'b0;
         st_q.oe <= 1'b0;
         st_q.pull_en <= ~FUNC_RST & DIR_RST;
         st_q.rd <= 1'b0;
      end
      else
         st_q <= st_d;
   end

   assign pad_out = st_q.out;
   assign pad_oe = st_q.oe;
   assign pad_pull_en = st_q.pull_en;
   assign pad_pull_up = PULL_UP;
   assign rd_val = st_q.rd;

endmodule
`default_nettype wire

/* File: pio_pkg.sv */
// Package for the 32-line programmable I/O port.
// Assumes a 32-bit AXI4-Lite register bus and one clock domain.
package pio_pkg;

   // Port geometry
   localparam int PIO_LINES = 32;       // Configurable lines
   localparam int PIO_HALF = 16;        // Lines per configuration word

   // Register byte offsets on the bus
   localparam logic [5:0] PIO_FUNC_LO_OFS = 6'h00; // Function select, 0-15
   localparam logic [5:0] PIO_FUNC_HI_OFS = 6'h04; // Function select, 16-31
   localparam logic [5:0] PIO_DIR_LO_OFS = 6'h08;  // Direction select, 0-15
   localparam logic [5:0] PIO_DIR_HI_OFS = 6'h0c;  // Direction select, 16-31
   localparam logic [5:0] PIO_DATA_LO_OFS = 6'h10; // Output data, 0-15
   localparam logic [5:0] PIO_DATA_HI_OFS = 6'h14; // Output data, 16-31
   localparam logic [5:0] PIO_PIN_LO_OFS = 6'h18;  // Pin state, 0-15
   localparam logic [5:0] PIO_PIN_HI_OFS = 6'h1c;  // Pin state, 16-31
   localparam logic [5:0] PIO_OD_LO_OFS = 6'h20;   // Open-drain, 0-15
   localparam logic [5:0] PIO_OD_HI_OFS = 6'h24;   // Open-drain, 16-31

   // Values after reset: lines 4-9 normal, the rest inputs with pull
   localparam logic [31:0] PIO_FUNC_RST = 32'h0000_0000;
   localparam logic [31:0] PIO_DIR_RST = 32'hffff_fc0f;
   localparam logic [31:0] PIO_DATA_RST = 32'h0000_0000;
   localparam logic [31:0] PIO_OD_RST = 32'h0000_0000;

   // Fixed pull sense per line: 1 pull-up, 0 pull-down (lines 1, 10)
   localparam logic [31:0] PIO_PULL_UP = 32'hffff_fbfd;
   // Lines behind board inverters (lines 12, 13, 30, 31)
   localparam logic [31:0] PIO_INVERTED = 32'hc000_3000;

   // AXI response codes
   localparam logic [1:0] PIO_RESP_OKAY = 2'h0;
   localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

   // Line modes, as {function bit, direction bit}
   typedef enum logic [1:0]
   {
      PIO_MODE_NORMAL,
      PIO_MODE_IN_PULL,
      PIO_MODE_OUT,
      PIO_MODE_IN_FREE
   } pio_mode_t;

endpackage

/* File: pio_port.sv */
// Top of the 32-line programmable I/O port with its AXI4-Lite slave.
// Assumes pins are synchronous to aclk; the board resolves pad wires.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pio_port
   import pio_pkg::*;
#(
   parameter int LINES = PIO_LINES // Line count, two words
)
(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Shared peripheral side of each line
   input wire logic [LINES-1:0] periph_out,
   input wire logic [LINES-1:0] periph_oe,
   // Header pins, five signals each
   input wire logic [LINES-1:0] pin_in,
   output logic [LINES-1:0] pin_out,
   output logic [LINES-1:0] pin_oe,
   output logic [LINES-1:0] pin_pull_en,
   output logic [LINES-1:0] pin_pull_up,
   // Configured-mode view for the peripherals
   output logic [LINES-1:0] line_function_select,
   output logic [LINES-1:0] line_direction_select
);

   // Whole bus-side state in one record
   typedef struct packed {
      // Write halves held until both are present
      logic aw_got;           // Write address held
      logic [5:0] aw_addr;    // Held write offset
      logic w_got;            // Write data held
      logic [31:0] w_data;    // Held write data
      logic [3:0] w_strb;     // Held byte enables
      // Channel readies and pending answers
      logic awready;          // Address channel ready
      logic wready;           // Data channel ready
      logic bvalid;           // Write response pending
      logic [1:0] bresp;      // Write response code
      logic arready;          // Read address ready
      logic rvalid;           // Read data pending
      logic [31:0] rdata;     // Read data
      logic [1:0] rresp;      // Read response code
      // Line configuration, bit n drives line n
      logic [31:0] func;      // Function select bits
      logic [31:0] dir;       // Direction select bits
      logic [31:0] data;      // Output data bits
      logic [31:0] od;        // Open-drain select bits
   } pio_st_t;

   pio_st_t st_q; // Registered state
   pio_st_t st_d; // Next state

   logic [LINES-1:0] rd_val; // Per-line read value

   // Readies drop once a write half is held and return only after
   // the response is taken, so a waiting half is never overwritten.
   // A read is answered next cycle; arready stays low until rdata is
   // taken, so one read at most is in flight.
   // Words hold 16 line bits in [15:0]; upper halves read as zero.

   // Merge byte lanes from the low half of a word; upper half is dropped
   function automatic logic [15:0] pio_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0])
         res[7:0] = wd[7:0];
      if (strb[1])
         res[15:8] = wd[15:8];
      // Lanes 3:2 map to no line and are dropped
      return res;
   endfunction

   // Does an offset name a writable register?
   function automatic logic pio_wr_ok(input logic [5:0] ofs);
      logic ok;
      ok = 1'b0;
      // Pin state words are read-only
      case (ofs)
         PIO_FUNC_LO_OFS, PIO_FUNC_HI_OFS,
         PIO_DIR_LO_OFS, PIO_DIR_HI_OFS,
         PIO_DATA_LO_OFS, PIO_DATA_HI_OFS,
         PIO_OD_LO_OFS, PIO_OD_HI_OFS:
            ok = 1'b1;
         default:
            ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Bus slave and register file
   always_comb
   begin
      logic [5:0] ofs;
      logic hit;
      ofs = 6'h00;
      hit = 1'b0;
      st_d = st_q;
      // Every field holds unless a branch below overrides it

      // Capture write address; accepted independently of data
      if (st_q.awready && s_axi_awvalid)
      begin
         st_d.aw_got = 1'b1;
         st_d.aw_addr = s_axi_awaddr[5:0];
         st_d.awready = 1'b0;
      end

      // Capture write data; either order is fine
      if (st_q.wready && s_axi_wvalid)
      begin
         st_d.w_got = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_strb = s_axi_wstrb;
         st_d.wready = 1'b0;
      end

      // Both halves present: commit and respond
      if (st_q.aw_got && st_q.w_got && !st_q.bvalid)
      begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         // Unaligned or unmapped offsets store nothing
         hit = pio_wr_ok(st_q.aw_addr);
         st_d.bresp = hit ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
         case (st_q.aw_addr)
            // Function select words
            PIO_FUNC_LO_OFS:
               st_d.func[15:0] = pio_merge(st_q.func[15:0],
                                           st_q.w_data, st_q.w_strb);
            PIO_FUNC_HI_OFS:
               st_d.func[31:16] = pio_merge(st_q.func[31:16],
                                            st_q.w_data, st_q.w_strb);

            // Direction select words
            PIO_DIR_LO_OFS:
               st_d.dir[15:0] = pio_merge(st_q.dir[15:0],
                                          st_q.w_data, st_q.w_strb);
            PIO_DIR_HI_OFS:
               st_d.dir[31:16] = pio_merge(st_q.dir[31:16],
                                           st_q.w_data, st_q.w_strb);

            // Output data words
            PIO_DATA_LO_OFS:
               st_d.data[15:0] = pio_merge(st_q.data[15:0],
                                           st_q.w_data, st_q.w_strb);
            PIO_DATA_HI_OFS:
               st_d.data[31:16] = pio_merge(st_q.data[31:16],
                                            st_q.w_data, st_q.w_strb);

            // Open-drain select words
            PIO_OD_LO_OFS:
               st_d.od[15:0] = pio_merge(st_q.od[15:0],
                                         st_q.w_data, st_q.w_strb);
            PIO_OD_HI_OFS:
               st_d.od[31:16] = pio_merge(st_q.od[31:16],
                                          st_q.w_data, st_q.w_strb);
            // Pin state words and holes store nothing
            default:
               st_d.bresp = PIO_RESP_SLVERR;
         endcase
      end

      // Retire write response
      // Readies return only now, which ends the write
      if (st_q.bvalid && s_axi_bready)
      begin
         st_d.bvalid = 1'b0;
         st_d.awready = 1'b1;
         st_d.wready = 1'b1;
      end

      // Read: one outstanding, answered one cycle after the address
      if (st_q.arready && s_axi_arvalid)
      begin
         ofs = s_axi_araddr[5:0];
         st_d.arready = 1'b0;
         st_d.rvalid = 1'b1;
         st_d.rresp = PIO_RESP_OKAY;
         st_d.rdata = 32'h0000_0000;
         case (ofs)
            // Function select words
            PIO_FUNC_LO_OFS:
               st_d.rdata[15:0] = st_q.func[15:0];
            PIO_FUNC_HI_OFS:
               st_d.rdata[15:0] = st_q.func[31:16];

            // Direction select words
            PIO_DIR_LO_OFS:
               st_d.rdata[15:0] = st_q.dir[15:0];
            PIO_DIR_HI_OFS:
               st_d.rdata[15:0] = st_q.dir[31:16];

            // Output data words
            PIO_DATA_LO_OFS:
               st_d.rdata[15:0] = st_q.data[15:0];
            PIO_DATA_HI_OFS:
               st_d.rdata[15:0] = st_q.data[31:16];

            // Live pin state, one cycle behind the pin
            PIO_PIN_LO_OFS:
               st_d.rdata[15:0] = rd_val[15:0];
            PIO_PIN_HI_OFS:
               st_d.rdata[15:0] = rd_val[31:16];

            // Open-drain select words
            PIO_OD_LO_OFS:
               st_d.rdata[15:0] = st_q.od[15:0];
            PIO_OD_HI_OFS:
               st_d.rdata[15:0] = st_q.od[31:16];
            default:
               // Unmapped address answers with an error, data zero
               st_d.rresp = PIO_RESP_SLVERR;
         endcase
      end

      // Retire read data
      // Address channel reopens only once the data is taken
      if (st_q.rvalid && s_axi_rready)
      begin
         st_d.rvalid = 1'b0;
         st_d.arready = 1'b1;
      end
   end

   // State register; configuration takes its reset defaults
   // Reset is synchronous; the line cells reset the pads on the same edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q.aw_got <= 1'b0;
         st_q.aw_addr <= 6'h00;
         st_q.w_got <= 1'b0;
         st_q.w_data <= 32'h0000_0000;
         st_q.w_strb <= 4'h0;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.bvalid <= 1'b0;
         st_q.bresp <= PIO_RESP_OKAY;
         st_q.arready <= 1'b1;
         st_q.rvalid <= 1'b0;
         st_q.rdata <= 32'h0000_0000;
         st_q.rresp <= PIO_RESP_OKAY;
         st_q.func <= PIO_FUNC_RST;
         st_q.dir <= PIO_DIR_RST;
         st_q.data <= PIO_DATA_RST;
         st_q.od <= PIO_OD_RST;
      end
      else
         st_q <= st_d;
   end

   // Bus outputs straight from the state register
   // No output is combinational, so the bus sees no loops
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign line_function_select = st_q.func;
   assign line_direction_select = st_q.dir;

   // Lines 26 and 29 reset as pulled inputs and so never drive low while
   // in reset; the board must not pull them low either.
   // Interrupts 0, 1 and 3 are separate pins and never reach this port.

   // One cell per line; pull sense and inverter are fixed per line
   // Each cell registers its own pad drive, so pads lag the
   // configuration words by one cycle
   genvar gi;
   generate
      for (gi = 0; gi < LINES; gi = gi + 1)
      begin : g_line
         pio_line #(
            .PULL_UP(PIO_PULL_UP[gi]),
            .INVERTED(PIO_INVERTED[gi]),
            .FUNC_RST(PIO_FUNC_RST[gi]),
            .DIR_RST(PIO_DIR_RST[gi])
         ) u_line (
            .aclk(aclk),
            .aresetn(aresetn),
            .func(st_q.func[gi]),
            .dir(st_q.dir[gi]),
            .open_drain(st_q.od[gi]),
            .dat(st_q.data[gi]),
            .periph_out(periph_out[gi]),
            .periph_oe(periph_oe[gi]),
            .pad_in(pin_in[gi]),
            .pad_out(pin_out[gi]),
            .pad_oe(pin_oe[gi]),
            .pad_pull_en(pin_pull_en[gi]),
            .pad_pull_up(pin_pull_up[gi]),
            .rd_val(rd_val[gi])
         );
      end
   endgenerate

endmodule
`default_nettype wire

/* File: pio_port_sva.sv */
// Checker for the I/O port: bus handshakes and pad outputs.
// Sees only pio_port ports; bound in at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module pio_port_sva
   import pio_pkg::*;
#(
   parameter int LINES = PIO_LINES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [LINES-1:0] periph_out,
   input wire logic [LINES-1:0] periph_oe,
   input wire logic [LINES-1:0] pin_out,
   input wire logic [LINES-1:0] pin_oe,
   input wire logic [LINES-1:0] pin_pull_en,
   input wire logic [LINES-1:0] pin_pull_up,
   input wire logic [LINES-1:0] line_function_select,
   input wire logic [LINES-1:0] line_direction_select
);
   localparam logic [LINES-1:0] INV = LINES'(PIO_INVERTED); // Inverter-fed
   logic [LINES-1:0] nrm_q; // Normal lines, last cycle
   logic [LINES-1:0] out_q; // Output lines, last cycle
   logic [LINES-1:0] pul_q; // Pulled inputs, last cycle
   logic [LINES-1:0] poe_q; // Peripheral enable, last cycle
   logic [LINES-1:0] pout_q; // Peripheral data, last cycle
   logic run_q; // Pads lag config, so skip the first edge
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Pads follow config one edge late
   always_ff @(posedge aclk)
   begin
      nrm_q <= ~line_function_select & ~line_direction_select;
      out_q <= line_function_select & ~line_direction_select;
      pul_q <= ~line_function_select & line_direction_select;
      poe_q <= periph_oe;
      pout_q <= periph_out;
      run_q <= aresetn;
   end

   // Both write halves taken together
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Answer on the second edge
   sequence wr_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence

   pull_sense_a: assert property (pin_pull_up == LINES'(PIO_PULL_UP))
      else $error("pull sense not fixed");
   pull_mode_a: assert property (run_q |-> pin_pull_en == pul_q)
      else $error("pull enable not from mode");
   oe_cause_a: assert property (run_q |->
      (pin_oe & ~((out_q & ~INV) | (nrm_q & poe_q))) == '0)
      else $error("pad driven without cause");
   normal_pass_a: assert property (run_q |->
      ((pin_oe ^ poe_q) & nrm_q & ~INV) == '0 &&
      ((pin_out ^ pout_q) & nrm_q & poe_q & ~INV) == '0)
      else $error("normal line not following peripheral");
   wr_resp_a: assert property (wr_both |=> wr_answer)
      else $error("write answer late");
   b_hold_a: assert property ($fell(s_axi_bvalid) |->
      $past(s_axi_bready) && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   r_hold_a: assert property ($fell(s_axi_rvalid) |->
      $past(s_axi_rready) && $stable(s_axi_rdata))
      else $error("read data dropped");
   rdata_hi_a: assert property (s_axi_rvalid |->
      s_axi_rdata[31:16] == 16'h0000)
      else $error("read word wider than sixteen");
endmodule

bind pio_port pio_port_sva #(.LINES(LINES)) u_sva
(
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .periph_out(periph_out),
   .periph_oe(periph_oe),
   .pin_out(pin_out),
   .pin_oe(pin_oe),
   .pin_pull_en(pin_pull_en),
   .pin_pull_up(pin_pull_up),
   .line_function_select(line_function_select),
   .line_direction_select(line_direction_select)
);
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the I/O port over AXI4-Lite.
// Assumes the board model and the bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none
module tb
   import pio_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, wr_resp, rd_resp;
   logic [31:0] p_out = '0, p_oe = '0, ext_en = '0, ext_val = '0;
   logic [31:0] pin_in, pin_out, pin_oe, pull_en, pull_up, fsel, dsel;
   integer seed = 32'hb34cb86d; // Fixed so runs repeat
   int num_errors = 0;
   int checked = 0;

   pio_port dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .periph_out(p_out), .periph_oe(p_oe),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pull_en(pull_en), .pin_pull_up(pull_up),
      .line_function_select(fsel), .line_direction_select(dsel));

   pio_board board (.aclk(aclk), .aresetn(aresetn), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pull_en(pull_en), .pin_pull_up(pull_up),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // 250 MHz clock
   initial
   begin
      forever #2 aclk = ~aclk;
   end

   task automatic report_and_stop();
      if (num_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask

   // Both halves offered at once; ready sampled mid-cycle
   task automatic axi_wr(input logic [5:0] a, input logic [15:0] d);
      logic aw_p, w_p, aw_t, w_t;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge aclk);
      awaddr <= {26'h0, a};
      wdata <= {16'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw_p || w_p)
      begin
         @(negedge aclk);
         aw_t = aw_p && awready;
         w_t = w_p && wready;
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         aw_p = aw_p && !aw_t;
         w_p = w_p && !w_t;
      end
      do @(negedge aclk); while (!bvalid);
      wr_resp = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= {26'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      d = rdata;
      rd_resp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   // Expected pad enable: normal follows peripheral, out mode drives
   function automatic logic [31:0] exp_oe(logic [31:0] f, dv, v, od, po);
      return (~f & ~dv & po) | (f & ~dv & ~PIO_INVERTED & ~(od & v));
   endfunction

   // Expected pad level: open-drain only ever pulls low
   function automatic logic [31:0] exp_out(logic [31:0] f, dv, v, od, po);
      return (~f & ~dv & po) | (f & ~dv & v & ~od);
   endfunction

   // Watchdog, far beyond the expected run
   initial
   begin
      #80000;
      num_errors++;
      report_and_stop();
   end

   initial
   begin
      logic [31:0] f, dv, v, od, d, eo;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk("fsel", 32'h0, fsel);
      chk("dsel", ~32'h0000_03f0, dsel);
      chk("pull_en", ~32'h0000_03f0, pull_en);
      chk("pull_up", ~32'h0000_0402, pull_up);
      chk("pin_oe", 32'h0, pin_oe);
      axi_rd(PIO_DIR_LO_OFS, d);
      chk("dir lo", 32'h0000_fc0f, d);
      // Outside drive on all but lines 0 and 1, which show their pulls
      v = $random(seed);
      ext_en <= 32'hffff_fffc;
      ext_val <= v;
      repeat (3) @(posedge aclk);
      axi_rd(PIO_PIN_LO_OFS, d);
      chk("pin lo", {16'h0, v[15:2] ^ 14'h0c00, 2'b01}, d);
      axi_rd(PIO_PIN_HI_OFS, d);
      chk("pin hi", {16'h0, v[31:16] ^ 16'hc000}, d);
      ext_en <= '0;
      for (int i = 0; i < 12; i++)
      begin
         f = $random(seed);
         dv = $random(seed);
         v = $random(seed);
         od = $random(seed);
         if (i < 4) f = {32{i[1]}};
         if (i < 4) dv = {32{i[0]}};
         p_out <= $random(seed);
         p_oe <= $random(seed) & ~PIO_INVERTED;
         axi_wr(PIO_FUNC_LO_OFS, f[15:0]);
         axi_wr(PIO_FUNC_HI_OFS, f[31:16]);
         axi_wr(PIO_DIR_LO_OFS, dv[15:0]);
         axi_wr(PIO_DIR_HI_OFS, dv[31:16]);
         axi_wr(PIO_DATA_LO_OFS, v[15:0]);
         axi_wr(PIO_DATA_HI_OFS, v[31:16]);
         axi_wr(PIO_OD_LO_OFS, od[15:0]);
         axi_wr(PIO_OD_HI_OFS, od[31:16]);
         repeat (3) @(negedge aclk);
         chk("fsel", f, fsel);
         chk("dsel", dv, dsel);
         eo = exp_oe(f, dv, v, od, p_oe);
         chk("pin_oe", eo, pin_oe);
         chk("pin_out", exp_out(f, dv, v, od, p_out) & eo,
            pin_out & eo);
         chk("pull_en", ~f & dv, pull_en);
         chk("bresp", {30'h0, PIO_RESP_OKAY}, {30'h0, wr_resp});
         axi_rd(PIO_OD_HI_OFS, d);
         chk("od hi", {16'h0, od[31:16]}, d);
         chk("rresp", {30'h0, PIO_RESP_OKAY}, {30'h0, rd_resp});
      end
      // Refused and unmapped places
      axi_wr(PIO_PIN_LO_OFS, 16'h1234);
      chk("bresp ro", {30'h0, PIO_RESP_SLVERR}, {30'h0, wr_resp});
      axi_wr(6'h28, 16'h5555);
      chk("bresp map", {30'h0, PIO_RESP_SLVERR}, {30'h0, wr_resp});
      axi_rd(6'h3c, d);
      chk("rresp map", {30'h0, PIO_RESP_SLVERR}, {30'h0, rd_resp});
      chk("rdata map", 32'h0, d);
      report_and_stop();
   end
endmodule
`default_nettype wire
